// File: hdl/fss_supervisor.sv
// Fault and shutdown supervisor for a boost LED driver.
`timescale 1ns/1ps
// Overview of operation
// - Overcurrent shuts device down within 3 us.
// - Overcurrent latch holds until qualified shutdown or a supply drop to off.
// - Overcurrent asserts the fault flag.
// - Overcurrent opens the input disconnect switch.
// - Enable only when both supply comparators high.
// - Disable after supply low over 50 us.
// - Supply below 4.35 V shuts down.
// - Long enable low enters shutdown from startup, run or fault, clears latches.
// - Shutdown keeps sinks off until enable high.
// - Mask selected detectors during startup.
// - Switch limit cuts one cycle, no fault.
// - Latched fault turns all drives off together.
module fss_supervisor
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_n,
  // Comparator and pin inputs.
  input wire logic input_oc_trip,
  input wire logic supply_above_rise,
  input wire logic sense_above_rise,
  input wire logic supply_above_fall,
  input wire logic supply_below_min,
  input wire logic en_dim_pin,
  input wire logic switch_cycle_current_limit,
  input wire logic switch_cycle_start,
  input wire logic startup_detect,
  // Drive outputs.
  output logic fault_n,
  output logic disconnect_gate_on,
  output logic boost_enable,
  output logic sink_enable,
  output logic low_power
);

  // ----------------------------------------------------------------
  // Synchronised inputs
  // ----------------------------------------------------------------
  logic oc_s; // Filtered overcurrent trip.
  logic en_s; // Filtered enable/dimming level.
  logic rise_s; // Supply above rising threshold.
  logic sense_s; // Sense pin above rising threshold.
  logic fall_s; // Supply above falling threshold.
  logic min_s; // Supply below the hard minimum.
  logic det_s; // A masked detector during startup.
  logic ilim_s; // Cycle limit event.
  logic cyc_s; // Start of a switching cycle.

  fss_sync u_oc (.core_clk(core_clk), .rst_n(rst_n), .pin_in(input_oc_trip), .level_out(oc_s));
  fss_sync u_en (.core_clk(core_clk), .rst_n(rst_n), .pin_in(en_dim_pin), .level_out(en_s));
  fss_sync u_rise (.core_clk(core_clk), .rst_n(rst_n), .pin_in(supply_above_rise), .level_out(rise_s));
  fss_sync u_sense (.core_clk(core_clk), .rst_n(rst_n), .pin_in(sense_above_rise), .level_out(sense_s));
  fss_sync u_fall (.core_clk(core_clk), .rst_n(rst_n), .pin_in(supply_above_fall), .level_out(fall_s));
  fss_sync u_min (.core_clk(core_clk), .rst_n(rst_n), .pin_in(supply_below_min), .level_out(min_s));
  fss_sync u_det (.core_clk(core_clk), .rst_n(rst_n), .pin_in(startup_detect), .level_out(det_s));
  fss_sync u_ilim (.core_clk(core_clk), .rst_n(rst_n), .pin_in(switch_cycle_current_limit), .level_out(ilim_s));
  fss_sync u_cyc (.core_clk(core_clk), .rst_n(rst_n), .pin_in(switch_cycle_start), .level_out(cyc_s));

  // ----------------------------------------------------------------
  // State and counters
  // ----------------------------------------------------------------
  fss_pkg::fss_state_t state_q; // Supervisor state.
  fss_pkg::fss_state_t state_d; // Next state.
  logic [fss_pkg::CNT_W-1:0] low_cnt_q; // Enable low time.
  logic [fss_pkg::CNT_W-1:0] uv_cnt_q; // Supply dip time.
  logic [fss_pkg::CNT_W-1:0] su_cnt_q; // Startup blanking time.
  logic fault_latch_q; // Latched severe fault.
  logic cyc_off_q; // Boost off for the rest of this cycle.
  logic cyc_s_q; // Previous cycle-start level for edge detect.
  logic fault_n_q;
  logic gate_q;
  logic boost_q;
  logic sink_q;
  logic lowp_q;

  // Saturating increment used by all three timers.
  function automatic logic [fss_pkg::CNT_W-1:0] sat_inc(input logic [fss_pkg::CNT_W-1:0] v);
    sat_inc = (v == {fss_pkg::CNT_W{1'b1}}) ? v : v + 16'h0001;
  endfunction

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire supply_ok = rise_s && sense_s;
  wire uv_expired = (uv_cnt_q > fss_pkg::CNT_W'(fss_pkg::UV_FILTER_CYC));
  wire hard_off = min_s || uv_expired;
  wire low_expired = (low_cnt_q >= fss_pkg::CNT_W'(fss_pkg::SHUTDOWN_LOW_CYC));
  wire in_startup = (state_q == fss_pkg::FSS_STARTUP);
  wire startup_done = (su_cnt_q >= fss_pkg::CNT_W'(fss_pkg::STARTUP_MASK_CYC));
  // The startup detector only counts outside the blanking window.
  wire det_fault = det_s && !in_startup && (state_q == fss_pkg::FSS_RUN);
  // Overcurrent is honoured in every state except off and shutdown, whatever the enable level.
  wire oc_fault = oc_s && (state_q != fss_pkg::FSS_OFF) && (state_q != fss_pkg::FSS_SHUTDOWN);
  wire cyc_rise = cyc_s && !cyc_s_q;
  wire run_drive = (state_d == fss_pkg::FSS_RUN);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      fss_pkg::FSS_OFF:
      begin
        // Wait for both comparators above the rising threshold.
        if (supply_ok && en_s)
        begin
          state_d = fss_pkg::FSS_STARTUP;
        end
      end
      fss_pkg::FSS_STARTUP:
      begin
        if (startup_done)
        begin
          state_d = fss_pkg::FSS_RUN;
        end
      end
      fss_pkg::FSS_RUN:
      begin
        if (low_expired)
        begin
          state_d = fss_pkg::FSS_SHUTDOWN;
        end
      end
      fss_pkg::FSS_FAULT:
      begin
        // Only a qualified low time or a supply drop to off releases a latched fault.
        if (low_expired)
        begin
          state_d = fss_pkg::FSS_SHUTDOWN;
        end
      end
      fss_pkg::FSS_SHUTDOWN:
      begin
        if (en_s)
        begin
          state_d = fss_pkg::FSS_OFF;
        end
      end
      default:
      begin
        state_d = fss_pkg::FSS_OFF;
      end
    endcase
    if (state_q == fss_pkg::FSS_STARTUP && low_expired)
    begin
      state_d = fss_pkg::FSS_SHUTDOWN;
    end
    if (oc_fault || det_fault)
    begin
      state_d = fss_pkg::FSS_FAULT;
    end
    if (hard_off)
    begin
      state_d = fss_pkg::FSS_OFF;
    end
  end

  // ----------------------------------------------------------------
  // State register and timers
  // ----------------------------------------------------------------
  // The low counter restarts on any high sample so dimming never trips it.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= fss_pkg::FSS_OFF;
      low_cnt_q <= 16'h0000;
      uv_cnt_q <= 16'h0000;
      su_cnt_q <= 16'h0000;
      cyc_s_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      low_cnt_q <= en_s ? 16'h0000 : sat_inc(low_cnt_q);
      uv_cnt_q <= fall_s ? 16'h0000 : sat_inc(uv_cnt_q);
      su_cnt_q <= in_startup ? sat_inc(su_cnt_q) : 16'h0000;
      cyc_s_q <= cyc_s;
    end
  end

  // ----------------------------------------------------------------
  // Fault latch and outputs
  // ----------------------------------------------------------------
  // Entering shutdown clears the latch, but a new trip in the same cycle wins.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fault_latch_q <= 1'b0;
      cyc_off_q <= 1'b0;
      fault_n_q <= 1'b1;
      gate_q <= 1'b0;
      boost_q <= 1'b0;
      sink_q <= 1'b0;
      lowp_q <= 1'b1;
    end
    else
    begin
      if (oc_fault || det_fault)
      begin
        fault_latch_q <= 1'b1;
      end
      else if (state_d == fss_pkg::FSS_SHUTDOWN || state_d == fss_pkg::FSS_OFF)
      begin
        fault_latch_q <= 1'b0;
      end
      // Cycle limit blanks only until the next cycle starts.
      if (ilim_s)
      begin
        cyc_off_q <= 1'b1;
      end
      else if (cyc_rise)
      begin
        cyc_off_q <= 1'b0;
      end
      fault_n_q <= !((oc_fault || det_fault) || (fault_latch_q && state_d == fss_pkg::FSS_FAULT));
      gate_q <= (state_d == fss_pkg::FSS_STARTUP) || run_drive;
      boost_q <= run_drive && !ilim_s && !cyc_off_q;
      sink_q <= run_drive;
      lowp_q <= (state_d == fss_pkg::FSS_SHUTDOWN);
    end
  end

  assign fault_n = fault_n_q;
  assign disconnect_gate_on = gate_q;
  assign boost_enable = boost_q;
  assign sink_enable = sink_q;
  assign low_power = lowp_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_oc_gate_off: assert property (@(posedge core_clk) disable iff (!rst_n)
    oc_fault |=> !disconnect_gate_on) else $error("Gate not off after overcurrent.");
  chk_oc_flag_set: assert property (@(posedge core_clk) disable iff (!rst_n)
    oc_fault |=> !fault_n) else $error("Fault flag not set by overcurrent.");
  chk_latch_holds: assert property (@(posedge core_clk) disable iff (!rst_n)
    (fault_latch_q && !low_expired && !hard_off) |=> fault_latch_q) else $error("Latch dropped early.");
  chk_all_off: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state_q == fss_pkg::FSS_FAULT) |-> (!boost_enable && !sink_enable && !disconnect_gate_on))
    else $error("Drive left on in fault.");
  chk_enable_needs: assert property (@(posedge core_clk) disable iff (!rst_n)
    ($past(state_q) == fss_pkg::FSS_OFF && state_q == fss_pkg::FSS_STARTUP) |-> $past(supply_ok))
    else $error("Enabled without supply.");
  chk_uv_filter: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!fall_s && uv_cnt_q < 16'h0010 && !min_s && state_q == fss_pkg::FSS_RUN && !oc_fault && !det_fault
     && !low_expired) |=> state_q == fss_pkg::FSS_RUN) else $error("Short dip disabled device.");
  chk_min_off: assert property (@(posedge core_clk) disable iff (!rst_n)
    min_s |=> state_q == fss_pkg::FSS_OFF) else $error("No shutdown below minimum supply.");
  chk_shutdown_sinks: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state_q == fss_pkg::FSS_SHUTDOWN) |-> (!sink_enable && low_power)) else $error("Sinks on in shutdown.");
  chk_low_restart: assert property (@(posedge core_clk) disable iff (!rst_n)
    en_s |=> low_cnt_q == 16'h0000) else $error("Low counter not restarted.");
  chk_climit_noflt: assert property (@(posedge core_clk) disable iff (!rst_n)
    (ilim_s && state_q == fss_pkg::FSS_RUN && state_d == fss_pkg::FSS_RUN)
    |=> (!boost_enable && fault_n && sink_enable))
    else $error("Cycle limit misbehaved.");

endmodule

// File: common/fss_pkg.sv
// Package of constants and types for the fault and shutdown supervisor.
package fss_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 200;                 // Core clock rate in MHz.
  localparam int OC_SHUTDOWN_NS = 3000;         // Longest overcurrent shutdown time in ns.
  localparam int OC_SHUTDOWN_CYC = (OC_SHUTDOWN_NS * CLK_MHZ) / 1000; // Rounded down.
  localparam int UV_FILTER_US = 50;             // Supply dip must last longer than this, in us.
  localparam int UV_FILTER_CYC = (UV_FILTER_US * CLK_MHZ + 999) / 1000 * 1000; // Rounded up.
  localparam int SHUTDOWN_LOW_CYC = 32750;      // Enable/dimming low cycles before shutdown.
  localparam int STARTUP_MASK_CYC = 1000;       // Startup blanking of masked detectors.
  localparam int CNT_W = 16;                    // Width of the shared counters.

  // ----------------------------------------------------------------
  // Supervisor states
  // ----------------------------------------------------------------
  typedef enum logic [2:0]
  {
    FSS_OFF,
    FSS_STARTUP,
    FSS_RUN,
    FSS_FAULT,
    FSS_SHUTDOWN
  } fss_state_t;

endpackage

// File: hdl/fss_sync.sv
// Three-stage synchroniser with agreement filter for one pin input.
`timescale 1ns/1ps
module fss_sync
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_n,
  // Pin and filtered level.
  input wire logic pin_in,
  output logic level_out
);

  // ----------------------------------------------------------------
  // Sampling chain
  // ----------------------------------------------------------------
  logic s1_q; // First stage, read only by the second.
  logic s2_q; // Second stage.
  logic s3_q; // Third stage.
  logic lvl_q; // Accepted level.

  // The level changes only when stages two and three agree.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      lvl_q <= 1'b0;
    end
    else
    begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
      begin
        lvl_q <= s3_q;
      end
    end
  end

  assign level_out = lvl_q;

endmodule

// File: tb/fss_ctrl_model.sv
// Behavioural model of the system controller on the enable/dimming pin.
`timescale 1ns/1ps
module fss_ctrl_model
(
  // Clock.
  input wire logic core_clk,
  // Pin side.
  input wire logic fault_n,
  output logic en_dim_pin
);
  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  // The pin starts high so the device may come up once supplies allow.
  initial en_dim_pin = 1'b1;
  // Sticky record of a seen fault, as a real controller would log it.
  logic fault_seen = 1'b0;
  // Samples the open-drain fault flag on every rising clock edge.
  always @(posedge core_clk)
  begin
    if (fault_n === 1'b0)
      fault_seen <= 1'b1;
  end
  // Holds the pin low for n cycles; the pin is released high only if asked.
  task automatic hold_low(input int n, input bit rel);
    begin
      @(posedge core_clk);
      en_dim_pin <= 1'b0;
      repeat (n) @(posedge core_clk);
      if (rel)
        en_dim_pin <= 1'b1;
      #1;
    end
  endtask
  // Returns the pin high just after an edge.
  task automatic set_high();
    begin
      @(posedge core_clk);
      en_dim_pin <= 1'b1;
      #1;
    end
  endtask
endmodule

// File: tb/testbench.sv
// Self-checking testbench for the fault and shutdown supervisor.
`timescale 1ns/1ps
module testbench;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic input_oc_trip = 1'b0;
  logic supply_above_rise = 1'b1;
  logic sense_above_rise = 1'b0; // Low first, so enabling must wait on it.
  logic supply_above_fall = 1'b1;
  logic supply_below_min = 1'b0;
  logic switch_cycle_current_limit = 1'b0;
  logic switch_cycle_start = 1'b0;
  logic startup_detect = 1'b0;
  logic en_dim_pin, fault_n, disconnect_gate_on, boost_enable, sink_enable, low_power;
  int bad_count = 0;
  int cmp_count = 0;
  // Output selectors for the bounded wait.
  localparam int W_FLT = 0, W_GATE = 1, W_BOOST = 2, W_SINK = 3, W_LP = 4;
  // ----------------------------------------------------------------
  // Clock, design and partner
  // ----------------------------------------------------------------
  initial forever #2.5 core_clk = ~core_clk;
  fss_supervisor DUT (.core_clk(core_clk), .rst_n(rst_n), .input_oc_trip(input_oc_trip),
    .supply_above_rise(supply_above_rise), .sense_above_rise(sense_above_rise),
    .supply_above_fall(supply_above_fall), .supply_below_min(supply_below_min), .en_dim_pin(en_dim_pin),
    .switch_cycle_current_limit(switch_cycle_current_limit), .switch_cycle_start(switch_cycle_start),
    .startup_detect(startup_detect), .fault_n(fault_n), .disconnect_gate_on(disconnect_gate_on),
    .boost_enable(boost_enable), .sink_enable(sink_enable), .low_power(low_power));
  fss_ctrl_model ctrl (.core_clk(core_clk), .fault_n(fault_n), .en_dim_pin(en_dim_pin));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    begin
      $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  // Compares one output bit; case inequality keeps an unknown from matching.
  task automatic chk(input logic got, input logic exp, input string what);
    begin
      cmp_count++;
      if (got !== exp)
      begin
        bad_count++;
        $display("ERROR at %0t: %s is %b, expected %b", $time, what, got, exp);
      end
    end
  endtask
  // Picks an output by selector.
  function automatic logic pick(input int k);
    case (k)
      W_FLT: pick = fault_n;
      W_GATE: pick = disconnect_gate_on;
      W_BOOST: pick = boost_enable;
      W_SINK: pick = sink_enable;
      default: pick = low_power;
    endcase
  endfunction
  // Waits at most lim cycles for an output level; running out ends the run.
  task automatic wait_for(input int k, input logic v, input int lim, input string what);
    int n;
    begin
      n = 0;
      while (pick(k) !== v && n < lim)
      begin
        @(posedge core_clk);
        #1;
        n++;
      end
      chk(pick(k), v, what);
      if (pick(k) !== v)
        results();
    end
  endtask
  // Lets n edges pass and samples settled values after the last.
  task automatic cyc(input int n);
    begin
      repeat (n) @(posedge core_clk);
      #1;
    end
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Enable waits for the sense comparator; startup masks its detector.
  task automatic t_enable();
    begin
      cyc(100);
      chk(disconnect_gate_on, 1'b0, "gate before sense ok");
      @(posedge core_clk) sense_above_rise <= 1'b1;
      wait_for(W_GATE, 1'b1, 10, "gate on");
      chk(boost_enable, 1'b0, "boost in startup");
      @(posedge core_clk) startup_detect <= 1'b1;
      cyc(200);
      chk(fault_n, 1'b1, "fault flag while masked");
      @(posedge core_clk) startup_detect <= 1'b0;
      wait_for(W_BOOST, 1'b1, fss_pkg::STARTUP_MASK_CYC + 10, "boost on");
      chk(sink_enable, 1'b1, "sinks on");
    end
  endtask
  // A switch limit cuts boost for one cycle and raises no fault.
  task automatic t_cycle_limit();
    begin
      @(posedge core_clk) switch_cycle_current_limit <= 1'b1;
      cyc(8);
      chk(boost_enable, 1'b0, "boost cut");
      chk(fault_n, 1'b1, "no fault on limit");
      chk(disconnect_gate_on & sink_enable, 1'b1, "gate and sinks kept");
      // The limit goes away mid-cycle; boost must stay off until the next cycle starts.
      @(posedge core_clk) switch_cycle_current_limit <= 1'b0;
      cyc(10);
      chk(boost_enable, 1'b0, "boost off for rest of cycle");
      @(posedge core_clk) switch_cycle_start <= 1'b1;
      wait_for(W_BOOST, 1'b1, 20, "boost next cycle");
      @(posedge core_clk) switch_cycle_start <= 1'b0;
    end
  endtask
  // Dimming lows shorter than the shutdown time never shut down.
  task automatic t_dim_pulses();
    begin
      ctrl.hold_low(17000, 1'b1);
      cyc(10);
      ctrl.hold_low(17000, 1'b1);
      cyc(10);
      chk(low_power, 1'b0, "no shutdown on pulses");
      chk(sink_enable, 1'b1, "sinks back on");
    end
  endtask
  // Overcurrent latches the fault and drops every drive together.
  task automatic t_overcurrent();
    begin
      @(posedge core_clk) input_oc_trip <= 1'b1;
      wait_for(W_FLT, 1'b0, fss_pkg::OC_SHUTDOWN_CYC, "fault flag in time");
      chk(disconnect_gate_on, 1'b0, "gate off");
      chk(boost_enable | sink_enable, 1'b0, "boost and sinks off");
      @(posedge core_clk) input_oc_trip <= 1'b0;
      cyc(50);
      chk(fault_n, 1'b0, "fault held");
      chk(ctrl.fault_seen, 1'b1, "controller saw the fault flag");
      chk(disconnect_gate_on, 1'b0, "gate held off");
    end
  endtask
  // A long enable low clears the latch; enable high restarts.
  task automatic t_shutdown();
    begin
      ctrl.hold_low(fss_pkg::SHUTDOWN_LOW_CYC - 10, 1'b0);
      chk(low_power, 1'b0, "no early shutdown");
      chk(fault_n, 1'b0, "fault kept until shutdown");
      cyc(40);
      chk(low_power, 1'b1, "low power");
      chk(fault_n, 1'b1, "latches cleared");
      chk(sink_enable, 1'b0, "sinks off in shutdown");
      cyc(100);
      chk(low_power, 1'b1, "stays shut down");
      ctrl.set_high();
      wait_for(W_GATE, 1'b1, 20, "restart gate");
      chk(low_power, 1'b0, "awake");
      wait_for(W_BOOST, 1'b1, fss_pkg::STARTUP_MASK_CYC + 10, "restart boost");
    end
  endtask
  // Short supply dips are ignored; long ones and a deep drop shut down.
  task automatic t_undervoltage();
    begin
      @(posedge core_clk) supply_above_fall <= 1'b0;
      cyc(100);
      @(posedge core_clk) supply_above_fall <= 1'b1;
      cyc(20);
      chk(boost_enable, 1'b1, "short dip ignored");
      @(posedge core_clk) supply_above_fall <= 1'b0;
      cyc(fss_pkg::UV_FILTER_CYC - 10);
      chk(boost_enable, 1'b1, "dip under filter time");
      cyc(100);
      chk(disconnect_gate_on | boost_enable, 1'b0, "off after long dip");
      @(posedge core_clk) supply_above_fall <= 1'b1;
      wait_for(W_BOOST, 1'b1, fss_pkg::STARTUP_MASK_CYC + 30, "back after dip");
      @(posedge core_clk) supply_below_min <= 1'b1;
      wait_for(W_GATE, 1'b0, 10, "deep drop off");
      chk(sink_enable, 1'b0, "sinks off on deep drop");
      @(posedge core_clk) supply_below_min <= 1'b0;
    end
  endtask
  // Outside startup the masked detector does raise a latched fault.
  task automatic t_detector();
    begin
      wait_for(W_BOOST, 1'b1, fss_pkg::STARTUP_MASK_CYC + 30, "back after deep drop");
      @(posedge core_clk) startup_detect <= 1'b1;
      wait_for(W_FLT, 1'b0, 10, "detector fault in run");
      chk(sink_enable | disconnect_gate_on, 1'b0, "drives off on detector fault");
      @(posedge core_clk) startup_detect <= 1'b0;
    end
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    cyc(5);
    chk(fault_n & low_power, 1'b1, "reset flag and low power");
    chk(disconnect_gate_on | boost_enable | sink_enable, 1'b0, "reset drives");
    @(posedge core_clk) rst_n <= 1'b1;
    t_enable();
    t_cycle_limit();
    t_dim_pulses();
    t_overcurrent();
    t_shutdown();
    t_undervoltage();
    t_detector();
    results();
  end
endmodule
